/* shared/ado_pkg.sv */
package ado_pkg;

	// Sample word width of each converter channel.
	localparam int SAMPLE_W = 14;

	// Half of a sample word, one bit per output lane per clock phase.
	localparam int LANE_W = SAMPLE_W / 2;

	// Latency in sampling clock cycles on the raw path and with digital functions on.
	localparam int RAW_LAT = 16;
	localparam int DIG_LAT = 24;

	// Extra pipeline stages behind the channel processor; it holds one stage itself.
	localparam int DIG_PIPE = DIG_LAT - RAW_LAT - 1;

	// Configuration frame: address byte, then data byte.
	localparam int CFG_ADDR_W = 8;
	localparam int CFG_DATA_W = 8;
	localparam int CFG_BITS   = CFG_ADDR_W + CFG_DATA_W;

	// Configuration addresses.
	localparam logic [7:0] ADDR_DIGITAL = 8'h01;
	localparam logic [7:0] ADDR_GAIN    = 8'h02;
	localparam logic [7:0] ADDR_OFFSET  = 8'h03;

	// Field positions inside the data byte.
	localparam int FLD_EN_DIG    = 0;
	localparam int FLD_GAIN_LO   = 0;
	localparam int FLD_OFS_EN    = 0;
	localparam int FLD_OFS_FRZ   = 1;
	localparam int FLD_OFS_TC_LO = 2;

	// Values after reset: digital path off, gain 0 dB, offset correction off.
	localparam logic       RST_EN_DIG = 1'b0;
	localparam logic [3:0] RST_GAIN   = 4'h0;
	localparam logic       RST_OFS_EN = 1'b0;
	localparam logic [3:0] RST_OFS_TC = 4'h0;

	// Control pin levels after reset, in synchroniser order samp_clk, sen_n, sclk, sdata.
	// Frame select idles high, so a reset value of zero would fake a frame end.
	localparam logic [3:0] RST_CTL_PINS = 4'h4;

	// Highest gain code: 13 settings of 0.5 dB from 0 dB to 6 dB.
	localparam logic [3:0] GAIN_MAX = 4'hC;

	// Gain multipliers in Q12, one per 0.5 dB step.
	localparam int GAIN_FRAC = 12;
	localparam logic [13:0] GAIN_COEF [0:12] = '{
		14'h1000, 14'h10F3, 14'h11F4, 14'h1304, 14'h1425, 14'h1556, 14'h169A,
		14'h17F1, 14'h195C, 14'h1ADD, 14'h1C74, 14'h1E24, 14'h1FED};

	// Fraction bits of the offset estimate.
	localparam int EST_FRAC = 10;

endpackage : ado_pkg

/* shared/ado_cfg_if.sv */
// Configuration carried from the top to each channel processor.
interface ado_cfg_if;
	logic       en_dig;  // Digital functions enabled.
	logic [3:0] gain;    // Gain code, 0.5 dB per step.
	logic       ofs_en;  // Offset correction enabled.
	logic       ofs_frz; // Offset estimate frozen.
	logic [3:0] ofs_tc;  // Offset loop shift, larger is slower.

	modport src (output en_dig, gain, ofs_en, ofs_frz, ofs_tc);
	modport snk (input en_dig, gain, ofs_en, ofs_frz, ofs_tc);
endinterface : ado_cfg_if

/* rtl/ado_chan.sv */
// One channel of digital processing: offset correction, then gain with saturation.
module ado_chan
	import ado_pkg::*;
(
	input  wire logic                clk,    // System clock.
	input  wire logic                resetn, // Synchronous reset, active low.
	input  wire logic                ce,     // Clock enable.
	input  wire logic                strobe, // One cycle per sample.
	ado_cfg_if.snk                   cfg,    // Shared configuration.
	input  wire logic [SAMPLE_W-1:0] din,    // Raw sample, two's complement.
	output logic      [SAMPLE_W-1:0] dout    // Processed sample, registered.
);

	localparam logic signed [17:0] SAT_MAX = 18'sh01FFF; // Largest 14-bit value.
	localparam logic signed [17:0] SAT_MIN = -18'sh02000; // Smallest 14-bit value.

	logic signed [23:0]         est_r;   // Offset estimate with fraction.
	logic signed [23:0]         est_nxt; // Next estimate.
	logic        [SAMPLE_W-1:0] dout_r;  // Output register.
	logic        [SAMPLE_W-1:0] dout_nxt; // Next output.
	logic signed [14:0]         corr;    // Sample after offset removal.
	logic signed [29:0]         prod;    // Gain product.
	logic signed [17:0]         scaled;  // Product back at sample scale.
	logic signed [24:0]         err;     // Sample minus estimate.
	logic signed [24:0]         step;    // Loop step after shift.

	assign dout = dout_r;

	// Offset loop and gain; the digital enable is checked here too, so a disabled path keeps no estimate.
	always_comb
	begin
		est_nxt  = est_r;
		dout_nxt = dout_r;
		err      = $signed({din[SAMPLE_W-1], din, 10'h000}) - $signed({est_r[23], est_r});
		step     = err >>> cfg.ofs_tc;
		corr     = $signed({din[SAMPLE_W-1], din});
		if (cfg.en_dig && cfg.ofs_en)
			corr = corr - $signed({est_r[23], est_r[23:EST_FRAC]});
		prod   = corr * $signed({1'b0, GAIN_COEF[cfg.gain]});
		scaled = prod[29:GAIN_FRAC];
		if (strobe)
		begin
			// Clearing the estimate while off means a restart begins from zero.
			if (!(cfg.en_dig && cfg.ofs_en))
				est_nxt = 24'sh000000;
			else if (!cfg.ofs_frz)
				est_nxt = est_r + step[23:0];
			// Saturate rather than wrap, so large gains clip cleanly.
			if (scaled > SAT_MAX)
				dout_nxt = 14'h1FFF;
			else if (scaled < SAT_MIN)
				dout_nxt = 14'h2000;
			else
				dout_nxt = scaled[SAMPLE_W-1:0];
		end
	end

	// Registers of the channel.
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			est_r  <= 24'sh000000;
			dout_r <= 14'h0000;
		end
		else if (ce)
		begin
			est_r  <= est_nxt;
			dout_r <= dout_nxt;
		end
	end

endmodule : ado_chan

/* rtl/ado_top.sv */
module ado_top
	import ado_pkg::*;
(
	input  wire logic                clk,                  // System clock, 250 MHz.
	input  wire logic                resetn,               // Synchronous reset, active low.
	input  wire logic                ce,                   // Clock enable, freezes all state when low.
	input  wire logic                samp_clk,             // Sampling clock pin.
	input  wire logic [SAMPLE_W-1:0] adc_a,                // Converter output, channel A.
	input  wire logic [SAMPLE_W-1:0] adc_b,                // Converter output, channel B.
	input  wire logic                cfg_sen_n,            // Config frame select, active low.
	input  wire logic                cfg_sclk,             // Config bit clock.
	input  wire logic                cfg_sdata,            // Config serial data.
	output logic                     sample_clock_out_pos, // Output clock.
	output logic      [LANE_W-1:0]   lane_a,               // DDR data lanes, channel A.
	output logic      [LANE_W-1:0]   lane_b                // DDR data lanes, channel B.
);

	// Pin synchroniser bit order: samp_clk, sen_n, sclk, sdata, adc_a, adc_b.
	localparam int PIN_W = 4 + 2 * SAMPLE_W;

	logic [PIN_W-1:0] s1_r;   // First synchroniser stage, read only by s2_r.
	logic [PIN_W-1:0] s2_r;   // Second stage, safe to use.
	logic [3:0]       s3_r;   // Previous value of the four control pins.
	logic [PIN_W-1:0] s1_nxt; // Next first stage.
	logic [PIN_W-1:0] s2_nxt; // Next second stage.
	logic [3:0]       s3_nxt; // Next previous-value stage.

	logic                samp_rise; // Sampling clock rising edge.
	logic                samp_fall; // Sampling clock falling edge.
	logic                sclk_rise; // Config bit clock rising edge.
	logic                sen_rise;  // End of a config frame.
	logic [SAMPLE_W-1:0] in_a;      // Synchronised channel A sample.
	logic [SAMPLE_W-1:0] in_b;      // Synchronised channel B sample.

	// Synchronisers: every pin passes two flops before any logic.
	always_comb
	begin
		s1_nxt = {samp_clk, cfg_sen_n, cfg_sclk, cfg_sdata, adc_a, adc_b};
		s2_nxt = s1_r;
		s3_nxt = s2_r[PIN_W-1 -: 4];
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			// Both stages start at the idle pin levels, so no false edge follows reset.
			s1_r <= {RST_CTL_PINS, {(2*SAMPLE_W){1'b0}}};
			s2_r <= {RST_CTL_PINS, {(2*SAMPLE_W){1'b0}}};
			s3_r <= RST_CTL_PINS;
		end
		else if (ce)
		begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
		end
	end

	// Edge detection on the second stage only.
	assign samp_rise = s2_r[PIN_W-1] && !s3_r[3];
	assign samp_fall = !s2_r[PIN_W-1] && s3_r[3];
	assign sen_rise  = s2_r[PIN_W-2] && !s3_r[2];
	assign sclk_rise = s2_r[PIN_W-3] && !s3_r[1];
	assign in_a      = s2_r[2*SAMPLE_W-1:SAMPLE_W];
	assign in_b      = s2_r[SAMPLE_W-1:0];

	logic [CFG_BITS-1:0] sh_r;       // Config shift register.
	logic [4:0]          cnt_r;      // Bits received in this frame.
	logic                en_dig_r;   // Digital functions enable.
	logic [3:0]          gain_r;     // Gain code.
	logic                ofs_en_r;   // Offset correction enable.
	logic                ofs_frz_r;  // Offset estimate freeze.
	logic [3:0]          ofs_tc_r;   // Offset loop time constant.
	logic [CFG_BITS-1:0] sh_nxt;     // Next shift register.
	logic [4:0]          cnt_nxt;    // Next bit count.
	logic                en_dig_nxt; // Next digital enable.
	logic [3:0]          gain_nxt;   // Next gain code.
	logic                ofs_en_nxt; // Next offset enable.
	logic                ofs_frz_nxt; // Next freeze.
	logic [3:0]          ofs_tc_nxt; // Next time constant.
	logic [7:0]          wr_addr;    // Address byte of the frame.
	logic [7:0]          wr_data;    // Data byte of the frame.

	assign wr_addr = sh_r[CFG_BITS-1 -: CFG_ADDR_W];
	assign wr_data = sh_r[CFG_DATA_W-1:0];

	// Config port: MSB first, a write lands only when the frame held at least 16 bits; bits past the 16th are ignored.
	always_comb
	begin
		sh_nxt      = sh_r;
		cnt_nxt     = cnt_r;
		en_dig_nxt  = en_dig_r;
		gain_nxt    = gain_r;
		ofs_en_nxt  = ofs_en_r;
		ofs_frz_nxt = ofs_frz_r;
		ofs_tc_nxt  = ofs_tc_r;
		if (s2_r[PIN_W-2])
			cnt_nxt = 5'h00;
		else if (sclk_rise && cnt_r != 5'(CFG_BITS))
		begin
			sh_nxt  = {sh_r[CFG_BITS-2:0], s2_r[PIN_W-4]};
			cnt_nxt = cnt_r + 5'h01;
		end
		if (sen_rise && cnt_r == 5'(CFG_BITS))
		begin
			// Decoding does not gate on the enable: the controller orders the writes.
			unique case (wr_addr)
				ADDR_DIGITAL:
					en_dig_nxt = wr_data[FLD_EN_DIG];
				ADDR_GAIN:
					// Codes past 6 dB are ignored so the coefficient index stays legal.
					if (wr_data[FLD_GAIN_LO +: 4] <= GAIN_MAX)
						gain_nxt = wr_data[FLD_GAIN_LO +: 4];
				ADDR_OFFSET:
				begin
					ofs_en_nxt  = wr_data[FLD_OFS_EN];
					ofs_frz_nxt = wr_data[FLD_OFS_FRZ];
					ofs_tc_nxt  = wr_data[FLD_OFS_TC_LO +: 4];
				end
				default:
					en_dig_nxt = en_dig_r;
			endcase
		end
	end

	// Config registers; reset values leave all digital functions off.
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			sh_r      <= '0;
			cnt_r     <= 5'h00;
			en_dig_r  <= RST_EN_DIG;
			gain_r    <= RST_GAIN;
			ofs_en_r  <= RST_OFS_EN;
			ofs_frz_r <= 1'b0;
			ofs_tc_r  <= RST_OFS_TC;
		end
		else if (ce)
		begin
			sh_r      <= sh_nxt;
			cnt_r     <= cnt_nxt;
			en_dig_r  <= en_dig_nxt;
			gain_r    <= gain_nxt;
			ofs_en_r  <= ofs_en_nxt;
			ofs_frz_r <= ofs_frz_nxt;
			ofs_tc_r  <= ofs_tc_nxt;
		end
	end

	ado_cfg_if cfg ();

	assign cfg.en_dig  = en_dig_r;
	assign cfg.gain    = gain_r;
	assign cfg.ofs_en  = ofs_en_r;
	assign cfg.ofs_frz = ofs_frz_r;
	assign cfg.ofs_tc  = ofs_tc_r;

	logic [2*SAMPLE_W-1:0] raw_r   [RAW_LAT];  // Raw sample pipeline, both channels.
	logic [2*SAMPLE_W-1:0] raw_nxt [RAW_LAT];  // Next raw pipeline.
	logic [2*SAMPLE_W-1:0] dig_r   [DIG_PIPE]; // Processed sample pipeline.
	logic [2*SAMPLE_W-1:0] dig_nxt [DIG_PIPE]; // Next processed pipeline.
	logic [SAMPLE_W-1:0]   proc_a;             // Processed channel A.
	logic [SAMPLE_W-1:0]   proc_b;             // Processed channel B.

	// Both channels see the same settings; one processor per channel.
	ado_chan u_chan_a (
		.clk    (clk),
		.resetn (resetn),
		.ce     (ce),
		.strobe (samp_rise),
		.cfg    (cfg),
		.din    (raw_r[RAW_LAT-1][2*SAMPLE_W-1:SAMPLE_W]),
		.dout   (proc_a)
	);

	ado_chan u_chan_b (
		.clk    (clk),
		.resetn (resetn),
		.ce     (ce),
		.strobe (samp_rise),
		.cfg    (cfg),
		.din    (raw_r[RAW_LAT-1][SAMPLE_W-1:0]),
		.dout   (proc_b)
	);

	// Pipelines advance once per sample; the digital path carries its extra stages.
	always_comb
	begin
		raw_nxt = raw_r;
		dig_nxt = dig_r;
		if (samp_rise)
		begin
			raw_nxt[0] = {in_a, in_b};
			for (int i = 1; i < RAW_LAT; i++)
				raw_nxt[i] = raw_r[i-1];
			dig_nxt[0] = {proc_a, proc_b};
			for (int i = 1; i < DIG_PIPE; i++)
				dig_nxt[i] = dig_r[i-1];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			raw_r <= '{default: '0};
			dig_r <= '{default: '0};
		end
		else if (ce)
		begin
			raw_r <= raw_nxt;
			dig_r <= dig_nxt;
		end
	end

	// Pick every second bit of a word, starting at the given phase.
	function automatic logic [LANE_W-1:0] ado_pick(input logic [SAMPLE_W-1:0] w, input logic odd);
		logic [LANE_W-1:0] r;
		r = '0;
		for (int i = 0; i < LANE_W; i++)
			r[i] = w[2*i + int'(odd)];
		return r;
	endfunction : ado_pick

	logic [2*SAMPLE_W-1:0] word_r;   // Word being sent this sample period.
	logic                  oclk_r;   // Output clock level.
	logic [LANE_W-1:0]     lane_a_r; // Channel A lanes.
	logic [LANE_W-1:0]     lane_b_r; // Channel B lanes.
	logic [2*SAMPLE_W-1:0] word_nxt; // Next word.
	logic                  oclk_nxt; // Next output clock.
	logic [LANE_W-1:0]     lane_a_nxt; // Next lanes A.
	logic [LANE_W-1:0]     lane_b_nxt; // Next lanes B.

	// DDR output: even bits with the clock high, odd bits with it low.
	always_comb
	begin
		word_nxt   = word_r;
		oclk_nxt   = oclk_r;
		lane_a_nxt = lane_a_r;
		lane_b_nxt = lane_b_r;
		if (samp_rise)
		begin
			// The enable steers this tap, so gain and offset cannot leak raw; ado_chan also checks it to gate the offset.
			word_nxt   = en_dig_r ? dig_r[DIG_PIPE-1] : raw_r[RAW_LAT-1];
			oclk_nxt   = 1'b1;
			lane_a_nxt = ado_pick(word_nxt[2*SAMPLE_W-1:SAMPLE_W], 1'b0);
			lane_b_nxt = ado_pick(word_nxt[SAMPLE_W-1:0], 1'b0);
		end
		else if (samp_fall)
		begin
			oclk_nxt   = 1'b0;
			lane_a_nxt = ado_pick(word_r[2*SAMPLE_W-1:SAMPLE_W], 1'b1);
			lane_b_nxt = ado_pick(word_r[SAMPLE_W-1:0], 1'b1);
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			word_r   <= '0;
			oclk_r   <= 1'b0;
			lane_a_r <= '0;
			lane_b_r <= '0;
		end
		else if (ce)
		begin
			word_r   <= word_nxt;
			oclk_r   <= oclk_nxt;
			lane_a_r <= lane_a_nxt;
			lane_b_r <= lane_b_nxt;
		end
	end

	assign sample_clock_out_pos = oclk_r;
	assign lane_a               = lane_a_r;
	assign lane_b               = lane_b_r;

endmodule : ado_top

/* tb/ado_rx_model.sv */
// Capture logic at the far side: rebuilds each 14-bit word from both output clock phases.
module ado_rx_model
	import ado_pkg::*;
(
	input  wire logic              clk,  // Capture clock.
	input  wire logic              oclk, // Output clock from the block.
	input  wire logic [LANE_W-1:0] la,   // Lanes, channel A.
	input  wire logic [LANE_W-1:0] lb,   // Lanes, channel B.
	output logic                   got,  // One-cycle pulse when a word is complete.
	output logic [SAMPLE_W-1:0]    wa,   // Rebuilt word, channel A.
	output logic [SAMPLE_W-1:0]    wb    // Rebuilt word, channel B.
);
	timeunit 1ns;
	timeprecision 100ps;

	logic              prev_r; // Output clock level one capture edge ago.
	logic [LANE_W-1:0] ea_r;   // Even bits held, channel A.
	logic [LANE_W-1:0] eb_r;   // Even bits held, channel B.

	initial
	begin
		prev_r = 1'b0;
		got    = 1'b0;
	end

	// Sampling on the system clock avoids racing the lanes against their own clock edge.
	always @(posedge clk)
	begin
		got <= 1'b0;
		if (oclk && !prev_r)
		begin
			ea_r <= la;
			eb_r <= lb;
		end
		if (!oclk && prev_r)
		begin
			// Odd bits sit beside the even ones of the same lane.
			for (int i = 0; i < LANE_W; i++)
			begin
				wa[2*i]   <= ea_r[i];
				wa[2*i+1] <= la[i];
				wb[2*i]   <= eb_r[i];
				wb[2*i+1] <= lb[i];
			end
			got <= 1'b1;
		end
		prev_r <= oclk;
	end
	// Only a low sampling rate is run, so no extra cycle of latency is allowed for.
endmodule : ado_rx_model

/* tb/ado_top_props.sv */
// Pin checks; the output clock is a delayed copy of the sampling clock.
module ado_top_props
	import ado_pkg::*;
(
	input wire logic              clk,                  // System clock.
	input wire logic              resetn,               // Synchronous reset, active low.
	input wire logic              ce,                   // Clock enable.
	input wire logic              samp_clk,             // Sampling clock pin.
	input wire logic              sample_clock_out_pos, // Output clock.
	input wire logic [LANE_W-1:0] lane_a,               // Lanes, channel A.
	input wire logic [LANE_W-1:0] lane_b                // Lanes, channel B.
);
	timeunit 1ns;
	timeprecision 100ps;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	// Reset clears every output, so no stale word leaves the block.
	property p_rst_zero;
		disable iff (1'b0) !resetn && ce |=> !sample_clock_out_pos && lane_a == '0 && lane_b == '0;
	endproperty
	a_rst_zero: assert property (p_rst_zero) else $error("Outputs not cleared in reset");
	// The synchroniser adds a short fixed delay; both edges must come through.
	property p_rise;
		$rose(samp_clk) |-> ##[2:4] $rose(sample_clock_out_pos);
	endproperty
	a_rise: assert property (p_rise) else $error("Output clock did not rise");
	property p_fall;
		$fell(samp_clk) |-> ##[2:4] $fell(sample_clock_out_pos);
	endproperty
	a_fall: assert property (p_fall) else $error("Output clock did not fall");
	// Lanes move only with an output clock edge, so a receiver on both edges sees settled bits.
	property p_hold_a;
		$stable(sample_clock_out_pos) |-> $stable(lane_a);
	endproperty
	a_hold_a: assert property (p_hold_a) else $error("Lane A moved between clock edges");
	property p_hold_b;
		$stable(sample_clock_out_pos) |-> $stable(lane_b);
	endproperty
	a_hold_b: assert property (p_hold_b) else $error("Lane B moved between clock edges");
	// Each output phase lasts as long as a sampling phase, at least three cycles.
	property p_high;
		$rose(sample_clock_out_pos) |=> sample_clock_out_pos [*2];
	endproperty
	a_high: assert property (p_high) else $error("Output clock high phase too short");
	property p_low;
		$fell(sample_clock_out_pos) |=> !sample_clock_out_pos [*2];
	endproperty
	a_low: assert property (p_low) else $error("Output clock low phase too short");
	// Without a sampling edge there is no output edge.
	property p_quiet;
		$stable(samp_clk) [*6] |-> $stable(sample_clock_out_pos);
	endproperty
	a_quiet: assert property (p_quiet) else $error("Output clock moved on its own");

	c_rise: cover property ($rose(sample_clock_out_pos));
	c_fall: cover property ($fell(sample_clock_out_pos));
	c_lane: cover property ($changed(lane_a));
endmodule : ado_top_props

bind ado_top ado_top_props i_ado_top_props (
	.clk(clk), .resetn(resetn), .ce(ce), .samp_clk(samp_clk),
	.sample_clock_out_pos(sample_clock_out_pos), .lane_a(lane_a), .lane_b(lane_b)
);

/* tb/adc_digital_output_path_tb.sv */
module adc_digital_output_path_tb;
	import ado_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	logic                clk, resetn, ce, samp_clk;     // Clock, reset, enable, sampling clock.
	logic [SAMPLE_W-1:0] adc_a, adc_b, wa, wb;          // Samples in, rebuilt words out.
	logic                cfg_sen_n, cfg_sclk, cfg_sdata; // Configuration pins.
	logic                oclk, got;                      // Output clock, word complete.
	logic [LANE_W-1:0]   lane_a, lane_b;                 // Output lanes.
	int                  va [2048], vb [2048];           // Sample taken at each sampling rise.
	int                  m, wj, lat_e, g_e, error_cnt, check_count; // Counters and expectations.
	bit                  run, rstr, chk_on;              // Sampling on, coarse values, checking on.

	ado_top i_ado_top (.clk(clk), .resetn(resetn), .ce(ce), .samp_clk(samp_clk), .adc_a(adc_a),
		.adc_b(adc_b), .cfg_sen_n(cfg_sen_n), .cfg_sclk(cfg_sclk), .cfg_sdata(cfg_sdata),
		.sample_clock_out_pos(oclk), .lane_a(lane_a), .lane_b(lane_b));
	ado_rx_model i_ado_rx_model (.clk(clk), .oclk(oclk), .la(lane_a), .lb(lane_b), .got(got), .wa(wa), .wb(wb));

	// Coarse values are multiples of 4096, so any gain product is exact whatever the rounding.
	function automatic int draw();
		if (rstr)
			return int'($urandom_range(3, 0)) * 4096 - 8192;
		return int'($urandom_range(16383, 0)) - 8192;
	endfunction : draw

	// Gain from the coefficient table, then saturation to 14 bits.
	function automatic logic [SAMPLE_W-1:0] expv(input int v, input int g);
		int r;
		r = v * int'(GAIN_COEF[g]) / 4096;
		if (r > 8191)
			r = 8191;
		if (r < -8192)
			r = -8192;
		return r[SAMPLE_W-1:0];
	endfunction : expv

	task automatic check(input logic [SAMPLE_W-1:0] seen, input logic [SAMPLE_W-1:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t word %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wrap_up();
		if (error_cnt == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up

	// Waits some clock edges, then steps just past the edge.
	task automatic tk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tk

	// Sends the top n bits of a frame, MSB first, with four cycles per bit clock phase.
	task automatic cfg(input logic [15:0] f, input int n);
		tk(1);
		cfg_sen_n = 1'b0;
		for (int i = 15; i > 15 - n; i--)
		begin
			cfg_sdata = f[i];
			tk(4);
			cfg_sclk = 1'b1;
			tk(4);
			cfg_sclk = 1'b0;
		end
		tk(4);
		cfg_sen_n = 1'b1;
		cfg_sdata = ~cfg_sdata;
		tk(6);
	endtask : cfg

	// Lets the old words drain, then checks twelve words against the new expectation.
	task automatic phase(input int g, input int lat, input bit rs);
		rstr = rs;
		repeat (30) @(posedge samp_clk);
		g_e    = g;
		lat_e  = lat;
		chk_on = 1'b1;
		repeat (12) @(posedge samp_clk);
		chk_on = 1'b0;
	endtask : phase

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// The sampling clock starts off the system clock grid, so its edges never meet a clock edge.
	initial
	begin
		void'($urandom(11143));
		samp_clk = 1'b0;
		adc_a    = '0;
		adc_b    = '0;
		wait (run);
		#1.3;
		forever
		begin
			va[m]    = draw();
			vb[m]    = draw();
			adc_a    = va[m][SAMPLE_W-1:0];
			adc_b    = vb[m][SAMPLE_W-1:0];
			samp_clk = 1'b0;
			#62.5 samp_clk = 1'b1;
			m++;
			#62.5;
		end
	end

	// Each rebuilt word is compared with the sample taken the expected number of edges before.
	always @(negedge clk)
	begin
		if (got === 1'b1)
		begin
			if (chk_on)
			begin
				check(wa, expv(va[wj - lat_e], g_e));
				check(wb, expv(vb[wj - lat_e], g_e));
			end
			wj++;
		end
	end

	initial
	begin
		ce        = 1'b1;
		resetn    = 1'b0;
		cfg_sen_n = 1'b1;
		cfg_sclk  = 1'b0;
		cfg_sdata = 1'b0;
		tk(20);
		resetn = 1'b1;
		run    = 1'b1;
		phase(0, RAW_LAT, 1'b0);
		cfg({ADDR_DIGITAL, 8'h01}, 16);
		phase(0, DIG_LAT, 1'b0);
		for (int g = 0; g <= 12; g++)
		begin
			cfg({ADDR_GAIN, 8'(g)}, 16);
			phase(g, DIG_LAT, 1'b1);
		end
		// Out-of-range code, short frame and unknown address all leave the gain alone.
		cfg({ADDR_GAIN, 8'h0D}, 16);
		cfg({ADDR_GAIN, 8'h00}, 15);
		cfg({8'h7F, 8'h00}, 16);
		phase(12, DIG_LAT, 1'b1);
		// Offset on but frozen: the estimate was cleared while off, so words stay unchanged.
		cfg({ADDR_OFFSET, 8'h03}, 16);
		phase(12, DIG_LAT, 1'b1);
		cfg({ADDR_OFFSET, 8'h00}, 16);
		cfg({ADDR_DIGITAL, 8'h00}, 16);
		phase(0, RAW_LAT, 1'b0);
		wrap_up();
	end

	// The run needs about 25000 cycles; this cuts a hang short.
	initial
	begin
		repeat (40000) @(posedge clk);
		error_cnt++;
		wrap_up();
	end
endmodule : adc_digital_output_path_tb
